//--- inc/lssw_consts.svh
// Constants of the low-side switch control block
`ifndef LSSW_CONSTS_SVH
`define LSSW_CONSTS_SVH
`define LSSW_NUM_CH 8
`define LSSW_NUM_SER 6
`define LSSW_BYTE_W 8
`define LSSW_OLE_LO 6
`define LSSW_OLE_HI 7
`define LSSW_CLK_MHZ 125
`define LSSW_REF_MS 3
`define LSSW_REF_CYC (`LSSW_REF_MS * 1000 * 1000 * `LSSW_CLK_MHZ / 1000)
`define LSSW_RETRY_US 25
`define LSSW_RETRY_CYC (`LSSW_RETRY_US * `LSSW_CLK_MHZ)
`endif

//--- inc/lssw_pkg.sv
// Types of the low-side switch control block
`default_nettype none
package lssw_pkg;
  typedef logic [7:0] lssw_byte_t;
  typedef enum logic [1:0] {LSSW_RUN, LSSW_REFRESH, LSSW_RETRY} lssw_short_t;
endpackage
`default_nettype wire

//--- rtl/lssw_short_retry.sv
// Per-channel short refresh and retry timer
`include "lssw_consts.svh"
`default_nettype none
module lssw_short_retry
  import lssw_pkg::*;
#(
  parameter int REF_CYC = `LSSW_REF_CYC,
  parameter int RETRY_CYC = `LSSW_RETRY_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic short_det,
  output logic allow
);
  lssw_short_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      LSSW_RUN: begin
        if (short_det) begin
          st_d = LSSW_REFRESH;
          cnt_d = 32'(REF_CYC);
        end
      end
      LSSW_REFRESH: begin
        if (cnt_q <= 32'h0000_0001) begin
          st_d = LSSW_RETRY;
          cnt_d = 32'(RETRY_CYC);
        end else begin
          cnt_d = cnt_q - 32'h0000_0001;
        end
      end
      LSSW_RETRY: begin
        if (cnt_q <= 32'h0000_0001) begin
          st_d = short_det ? LSSW_REFRESH : LSSW_RUN;
          cnt_d = 32'(REF_CYC);
        end else begin
          cnt_d = cnt_q - 32'h0000_0001;
        end
      end
      default: begin
        st_d = LSSW_RUN;
        cnt_d = 32'h0000_0000;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= LSSW_RUN;
      cnt_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end
  // Disabled only while waiting out the refresh interval
  assign allow = (st_q != LSSW_REFRESH);
endmodule
`default_nettype wire

//--- rtl/lssw_top.sv
// Serial and parallel control of the eight-channel low-side switch
// Functional notes
// - Mode high: serial bits ignored by gates, still latched and drive open-load enable, shifting continues
// - Mode high: parallel inputs 0-5 ignored
// - Mode high: override pins drive channel pairs
// - Mode low: override pins ignored
// - Mode high: channels six, seven forced off
// - Mode high: serial output tri-stated
// - Command bits 5..0 switch channels 5..0
// - Bits 6,7 enable on-state open-load detection
// - Normal: channel on if serial OR parallel
// - Status one means fault, channel 7 first
// - High gate turns switch on
// - Over-voltage turns six serial channels off
// - Channels six, seven parallel only, still reported
// - Open mode pin high, other inputs low
// - Select rising latches received command byte
// - Fault status frozen while select low
// - 16-bit frame returns status, then echo
// - Shorted channel disabled for refresh, then retried
`include "lssw_consts.svh"
`default_nettype none
module lssw_top
  import lssw_pkg::*;
#(
  parameter int NUM_CH = `LSSW_NUM_CH,
  parameter int REF_CYC = `LSSW_REF_CYC,
  parameter int RETRY_CYC = `LSSW_RETRY_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic mode_sel,
  input wire logic override_pin_a,
  input wire logic override_pin_b,
  input wire logic override_pin_c,
  input wire logic [NUM_CH-1:0] parallel_channel_inputs,
  input wire logic battery_supply_overvolt,
  input wire logic [NUM_CH-1:0] fault_in,
  input wire logic [NUM_CH-1:0] short_in,
  output logic [NUM_CH-1:0] gate_out,
  output logic open_load_enable
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NSYNC = 8 + 3 * NUM_CH;
  // Select starts deselected so reset release shows no select edge
  localparam logic [NSYNC-1:0] SYNC_RST = {1'b1, {(NSYNC-1){1'b0}}};
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
  // Pins left open are resolved by the pad pulls, mode pin high
  assign raw = {cs_n, sclk, sdi, mode_sel, override_pin_a, override_pin_b,
                override_pin_c, battery_supply_overvolt, parallel_channel_inputs, fault_in,
                short_in};
  // A change counts once the second and third stages agree
  always_comb begin
    for (int i = 0; i < NSYNC; i++) begin
      flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      flt_q <= SYNC_RST;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
    end
  end
  logic cs_s, sclk_s, sdi_s, mode_s, ova, ovb, ovc, ovp_s;
  logic [NUM_CH-1:0] par_s, flt_s, shr_s;
  assign {cs_s, sclk_s, sdi_s, mode_s, ova, ovb, ovc, ovp_s, par_s, flt_s, shr_s} = flt_q;

  // ****************************************
  // Serial shift engine
  // ****************************************
  logic sclk_prev_q, cs_prev_q;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall;
  lssw_byte_t rx_q, rx_d, tx_q, tx_d, cmd_q, cmd_d, stat_q, stat_d;
  logic sdo_q, sdo_d, oe_q, oe_d;
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign cs_rise = cs_s & ~cs_prev_q;
  assign cs_fall = ~cs_s & cs_prev_q;
  always_comb begin
    rx_d = rx_q;
    tx_d = tx_q;
    cmd_d = cmd_q;
    stat_d = stat_q;
    // Status open only while deselected
    if (cs_s) begin
      stat_d = flt_s;
    end
    if (cs_fall) begin
      tx_d = stat_q;
    end else if (!cs_s && sclk_rise) begin
      // Shift continues even in fallback mode
      rx_d = {rx_q[6:0], sdi_s};
      // Received bits queue behind status for echo and chaining
      tx_d = {tx_q[6:0], sdi_s};
    end
    if (cs_rise) begin
      cmd_d = rx_q;
    end
  end
  // Previous levels start at the idle levels, so no false edge follows reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      cmd_q <= 8'h00;
      stat_q <= 8'h00;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_s;
      rx_q <= rx_d;
      tx_q <= tx_d;
      cmd_q <= cmd_d;
      stat_q <= stat_d;
    end
  end

  // ****************************************
  // Serial output pin
  // ****************************************
  // Loaded with status bit 7 at select fall, advanced on falling clock
  always_comb begin
    sdo_d = sdo_q;
    if (cs_fall) begin
      sdo_d = stat_q[7];
    end else if (!cs_s && sclk_fall) begin
      sdo_d = tx_q[7];
    end
    // Output enabled only when selected and mode low
    oe_d = ~cs_s & ~mode_s;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
      oe_q <= oe_d;
    end
  end
  assign sdo = sdo_q;
  assign sdo_oe = oe_q;

  // ****************************************
  // Channel control
  // ****************************************
  logic [NUM_CH-1:0] allow, gate_q, gate_d;
  logic ole_q, ole_d;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      lssw_short_retry #(
        .REF_CYC(REF_CYC),
        .RETRY_CYC(RETRY_CYC)
      ) u_retry (
        .clk(clk),
        .nrst(nrst),
        .short_det(shr_s[g]),
        .allow(allow[g])
      );
    end
  endgenerate
  // Fallback pairs: override a, b, c feed channels 0-1, 2-3, 4-5
  logic [2:0] ovr;
  assign ovr = {ovc, ovb, ova};
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (i < `LSSW_NUM_SER) begin
        if (mode_s) begin
          gate_d[i] = ovr[i/2];
        end else begin
          gate_d[i] = cmd_q[i] | par_s[i];
        end
        if (ovp_s) begin
          gate_d[i] = 1'b0;
        end
      end else begin
        gate_d[i] = par_s[i] & ~mode_s;
      end
      // High gate means switch on
      gate_d[i] = gate_d[i] & allow[i];
    end
    ole_d = cmd_q[`LSSW_OLE_LO] | cmd_q[`LSSW_OLE_HI];
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gate_q <= '0;
      ole_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
      ole_q <= ole_d;
    end
  end
  assign gate_out = gate_q;
  assign open_load_enable = ole_q;
endmodule
`default_nettype wire

//--- sim/lssw_host.sv
// Host serial master model for the switch control block
`default_nettype none
module lssw_host (
  output var logic cs_n,
  output var logic sclk,
  output var logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Frame driver
  // ****************************************
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Reply bit taken late in the high phase, past the device's pin latency
  task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      #32 sclk = 1'b1;
      #30 rx = {rx[14:0], sdo};
      #2 sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    sdi = 1'b0;
    #400;
  endtask
endmodule
`default_nettype wire

//--- sim/lssw_monitor.sv
// Port checker of the switch control block
`default_nettype none
module lssw_monitor
  import lssw_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic mode_sel,
  input wire logic override_pin_a,
  input wire logic override_pin_b,
  input wire logic override_pin_c,
  input wire logic [NUM_CH-1:0] parallel_channel_inputs,
  input wire logic battery_supply_overvolt,
  input wire logic [NUM_CH-1:0] fault_in,
  input wire logic [NUM_CH-1:0] short_in,
  input wire logic [NUM_CH-1:0] gate_out,
  input wire logic open_load_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_mode;
    mode_sel [*8];
  endsequence
  a_mode_tri: assert property (s_mode |-> !sdo_oe)
    else $error("sdo driven in fallback");
  a_mode_six_off: assert property (s_mode |-> gate_out[7:6] == 2'b00)
    else $error("channel 6 or 7 on in fallback");
  a_pair_a_on: assert property ((s_mode and (override_pin_a && !battery_supply_overvolt) [*8])
    |-> gate_out[1:0] == 2'b11)
    else $error("pair a not on");
  a_pair_b_off: assert property ((mode_sel && !override_pin_b) [*8] |-> gate_out[3:2] == 2'b00)
    else $error("pair b on");
  a_ovp_off: assert property (battery_supply_overvolt [*6] |-> gate_out[5:0] == 6'h00)
    else $error("channel on in overvoltage");
  a_par_or: assert property ((!mode_sel && !battery_supply_overvolt &&
    parallel_channel_inputs[2]) [*8] |-> gate_out[2])
    else $error("parallel input ignored");
  a_six_par: assert property ((!parallel_channel_inputs[6]) [*8] |-> !gate_out[6])
    else $error("channel 6 on without input");
  a_idle_tri: assert property (cs_n [*8] |-> !sdo_oe)
    else $error("sdo driven while idle");
  a_cmd_hold: assert property ((!cs_n) [*8] |-> $stable(open_load_enable))
    else $error("command changed in frame");
endmodule
bind lssw_top lssw_monitor #(.NUM_CH(NUM_CH)) lssw_monitor_i (
  .clk(clk),
  .nrst(nrst),
  .cs_n(cs_n),
  .sclk(sclk),
  .sdi(sdi),
  .sdo(sdo),
  .sdo_oe(sdo_oe),
  .mode_sel(mode_sel),
  .override_pin_a(override_pin_a),
  .override_pin_b(override_pin_b),
  .override_pin_c(override_pin_c),
  .parallel_channel_inputs(parallel_channel_inputs),
  .battery_supply_overvolt(battery_supply_overvolt),
  .fault_in(fault_in),
  .short_in(short_in),
  .gate_out(gate_out),
  .open_load_enable(open_load_enable)
);
`default_nettype wire

//--- sim/lssw_top_tb_top.sv
// Testbench of the switch control block
`default_nettype none
module lssw_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, mode_sel = 1'b0, ova = 1'b0, ovb = 1'b0, ovc = 1'b0, ovp = 1'b0;
  logic [7:0] par = 8'h00, flt = 8'h00, shr = 8'h00;
  wire logic [7:0] gate;
  wire logic cs_n, sclk, sdi, sdo, sdo_oe, ole;
  wire logic sdo_line;
  // Pull-up on the serial line while the block releases it
  assign sdo_line = sdo_oe ? sdo : 1'b1;
  logic [15:0] rx;
  int bad_count = 0, checked = 0;
  always #4 clk = ~clk;
  lssw_top #(.REF_CYC(20), .RETRY_CYC(5)) lssw_top_i (.clk(clk), .nrst(nrst), .cs_n(cs_n),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .mode_sel(mode_sel),
    .override_pin_a(ova), .override_pin_b(ovb), .override_pin_c(ovc),
    .parallel_channel_inputs(par), .battery_supply_overvolt(ovp), .fault_in(flt),
    .short_in(shr), .gate_out(gate), .open_load_enable(ole));
  lssw_host lssw_host_i (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_line));
  // ****************************************
  // Tasks
  // ****************************************
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task set_in(input logic m, input logic [2:0] ov, input logic [7:0] p, input logic v);
    @(posedge clk);
    mode_sel <= m;
    {ova, ovb, ovc} <= ov;
    par <= p;
    ovp <= v;
    repeat (12) @(posedge clk);
    #1;
  endtask
  task t_serial;
    flt <= 8'h81;
    set_in(1'b0, 3'b000, 8'h00, 1'b0);
    chk({8'h00, gate}, 16'h0000);
    lssw_host_i.xfer(16, 16'hA53F, rx);
    chk(rx, 16'h81A5);
    chk({7'h00, ole, gate}, 16'h003F);
    lssw_host_i.xfer(8, 16'h00C1, rx);
    chk(rx, 16'h0081);
    chk({7'h00, ole, gate}, 16'h0101);
  endtask
  task t_or;
    set_in(1'b0, 3'b000, 8'h86, 1'b0);
    chk({8'h00, gate}, 16'h0087);
  endtask
  task t_mode;
    set_in(1'b1, 3'b101, 8'hFF, 1'b0);
    chk({8'h00, gate}, 16'h0033);
    lssw_host_i.xfer(8, 16'h000C, rx);
    chk(rx, 16'h00FF);
    chk({8'h00, gate}, 16'h0033);
    set_in(1'b0, 3'b111, 8'h00, 1'b0);
    chk({8'h00, gate}, 16'h000C);
  endtask
  task t_ovp;
    set_in(1'b0, 3'b000, 8'hFF, 1'b1);
    chk({8'h00, gate}, 16'h00C0);
    set_in(1'b0, 3'b000, 8'h00, 1'b0);
    chk({8'h00, gate}, 16'h000C);
  endtask
  task t_short;
    set_in(1'b0, 3'b000, 8'h01, 1'b0);
    chk({8'h00, gate}, 16'h000D);
    shr <= 8'h01;
    repeat (8) @(posedge clk);
    #1;
    chk({8'h00, gate}, 16'h000C);
    repeat (20) @(posedge clk);
    #1;
    chk({8'h00, gate}, 16'h000D);
    repeat (5) @(posedge clk);
    #1;
    chk({8'h00, gate}, 16'h000C);
    shr <= 8'h00;
    repeat (50) @(posedge clk);
    #1;
    chk({8'h00, gate}, 16'h000D);
  endtask
  task t_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk({7'h00, ole, gate}, 16'h0001);
    lssw_host_i.xfer(8, 16'h0000, rx);
    chk(rx, 16'h0081);
    chk({7'h00, ole, gate}, 16'h0001);
  endtask
  task print_verdict;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    t_serial();
    t_or();
    t_mode();
    t_ovp();
    t_short();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
